// *** hw/deser_cfg_pkg.sv ***
package deser_cfg_pkg;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int DEV_ADDR_W = 7;

  // register offsets
  localparam logic [7:0] OFS_DESER_CONFIG_ONE = 8'h00;
  localparam logic [7:0] OFS_BUS_ADDRESS_SETUP = 8'h01;
  localparam logic [7:0] OFS_DESER_FEATURES_ONE = 8'h02;
  localparam logic [7:0] OFS_DESER_FEATURES_TWO = 8'h03;

  // deser_config_one fields
  localparam int BIT_REG_CONTROL = 0;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_OUT_SLEEP_SEL = 6;
  localparam int BIT_LOW_FREQ_RANGE = 7;

  // bus_address_setup fields
  localparam int BIT_ADDR_FROM_REG = 7;
  localparam int ADDR_FIELD_MSB = 6;

  // deser_features_one fields
  localparam int BIT_DRIVE_ON = 7;
  localparam int BIT_SWING_SEL = 3;
  localparam int OSC_MSB = 2;

  // deser_features_two fields
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 5;
  localparam int BIT_BOOST_ON = 4;
  localparam int SPREAD_MSB = 2;

  // reset values
  localparam logic [7:0] RST_DESER_CONFIG_ONE = 8'h00;
  localparam logic [7:0] RST_BUS_ADDRESS_SETUP = 8'h70;
  localparam logic [7:0] RST_DESER_FEATURES_ONE = 8'h00;
  localparam logic [7:0] RST_DESER_FEATURES_TWO = 8'h00;

  // the four legal bus addresses, by strap level 0..3
  localparam logic [6:0] BUS_ADDR_0 = 7'h71;
  localparam logic [6:0] BUS_ADDR_1 = 7'h72;
  localparam logic [6:0] BUS_ADDR_2 = 7'h73;
  localparam logic [6:0] BUS_ADDR_3 = 7'h76;

  // oscillator frequencies in kHz, nominal (+/-40 %)
  localparam logic [14:0] OSC_KHZ_2 = 15'h61A8;
  localparam logic [14:0] OSC_KHZ_3 = 15'h413C;
  localparam logic [14:0] OSC_KHZ_4 = 15'h30D4;
  localparam logic [14:0] OSC_KHZ_5 = 15'h2710;
  localparam logic [14:0] OSC_KHZ_6 = 15'h206C;
  localparam logic [14:0] OSC_KHZ_7 = 15'h189C;
  localparam logic [2:0] OSC_CODE_OFF = 3'h0;
  localparam logic [2:0] OSC_CODE_RSVD = 3'h1;

  // boost gain step in milli-dB; gain = step * (code + 1)
  localparam logic [13:0] GAIN_STEP_MDB = 14'h0659;

  // spread profile modulation dividers
  localparam logic [11:0] SPREAD_DIV_HI_A = 12'h878;
  localparam logic [11:0] SPREAD_DIV_HI_B = 12'h514;
  localparam logic [11:0] SPREAD_DIV_LO_A = 12'h271;
  localparam logic [11:0] SPREAD_DIV_LO_B = 12'h181;
endpackage

// *** hw/spread_profile_decode.sv ***
`timescale 1ns/1ps
module spread_profile_decode
(
  // selection
  input wire logic low_freq_range_sel_in,
  input wire logic [2:0] spread_profile_sel_in,
  // decoded profile
  output logic spread_on_out,
  output logic [7:0] spread_dev_out,
  output logic [11:0] spread_div_out
);
  import deser_cfg_pkg::*;

  // deviation in hundredths of a percent
  function automatic logic [7:0] dev_of(input logic lo, input logic [2:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (!lo)
    begin
      unique case (c)
        3'h1: d = 8'h5A;
        3'h2: d = 8'h78;
        3'h3: d = 8'hBE;
        3'h4: d = 8'hE6;
        3'h5: d = 8'h46;
        3'h6: d = 8'h82;
        3'h7: d = 8'h9D;
        default: d = 8'h00;
      endcase
    end
    else
    begin
      unique case (c)
        3'h1: d = 8'h46;
        3'h2: d = 8'h82;
        3'h3: d = 8'hB4;
        3'h4: d = 8'hDC;
        3'h5: d = 8'h46;
        3'h6: d = 8'h78;
        3'h7: d = 8'hAA;
        default: d = 8'h00;
      endcase
    end
    return d;
  endfunction

  wire logic on_w = (spread_profile_sel_in != 3'h0);
  wire logic fast_w = spread_profile_sel_in[2] && (spread_profile_sel_in[1:0] != 2'h0);
  wire logic [11:0] div_hi_w = fast_w ? SPREAD_DIV_HI_B : SPREAD_DIV_HI_A;
  wire logic [11:0] div_lo_w = fast_w ? SPREAD_DIV_LO_B : SPREAD_DIV_LO_A;

  assign spread_on_out = on_w;
  assign spread_dev_out = dev_of(low_freq_range_sel_in, spread_profile_sel_in);
  assign spread_div_out = !on_w ? 12'h000 : (low_freq_range_sel_in ? div_lo_w : div_hi_w);
endmodule

// *** hw/deser_config_register_bank.sv ***
`timescale 1ns/1ps
module deser_config_register_bank
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // power and link state
  input wire logic power_down_input_n_in,
  input wire logic stream_stopped_in,
  // register access from the serial bus engine
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [deser_cfg_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [deser_cfg_pkg::REG_W-1:0] reg_wdata_in,
  output logic [deser_cfg_pkg::REG_W-1:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  output logic reg_addr_err_out,
  // strap pins
  input wire logic [1:0] addr_select_level_in,
  input wire logic pin_low_freq_range_sel_in,
  input wire logic pin_output_sleep_state_sel_in,
  input wire logic pin_video_output_drive_on_in,
  input wire logic pin_output_swing_sel_in,
  input wire logic [2:0] pin_internal_osc_freq_sel_in,
  input wire logic pin_input_boost_on_in,
  input wire logic [2:0] pin_input_boost_gain_in,
  input wire logic [2:0] pin_spread_profile_sel_in,
  // effective settings
  output logic reg_control_out,
  output logic sleep_out,
  output logic output_sleep_state_sel_out,
  output logic [deser_cfg_pkg::DEV_ADDR_W-1:0] device_address_out,
  output logic device_address_reserved_out,
  output logic video_output_drive_on_out,
  output logic output_swing_sel_out,
  output logic [2:0] internal_osc_freq_sel_out,
  output logic [14:0] osc_freq_khz_out,
  output logic internal_osc_freq_sel_reserved_out,
  output logic input_boost_on_out,
  output logic [2:0] input_boost_gain_out,
  output logic [13:0] boost_gain_mdb_out,
  output logic low_freq_range_sel_out,
  output logic spread_on_out,
  output logic [7:0] spread_dev_out,
  output logic [11:0] spread_div_out
);
  import deser_cfg_pkg::*;

  function automatic logic [6:0] strap_addr(input logic [1:0] lvl);
    logic [6:0] a;
    a = BUS_ADDR_3;
    unique case (lvl)
      2'h0: a = BUS_ADDR_0;
      2'h1: a = BUS_ADDR_1;
      2'h2: a = BUS_ADDR_2;
      2'h3: a = BUS_ADDR_3;
    endcase
    return a;
  endfunction

  function automatic logic addr_valid(input logic [6:0] a);
    return (a == BUS_ADDR_0) || (a == BUS_ADDR_1) || (a == BUS_ADDR_2) || (a == BUS_ADDR_3);
  endfunction

  function automatic logic [14:0] osc_khz(input logic [2:0] c);
    logic [14:0] f;
    f = 15'h0000;
    unique case (c)
      3'h2: f = OSC_KHZ_2;
      3'h3: f = OSC_KHZ_3;
      3'h4: f = OSC_KHZ_4;
      3'h5: f = OSC_KHZ_5;
      3'h6: f = OSC_KHZ_6;
      3'h7: f = OSC_KHZ_7;
      default: f = 15'h0000;
    endcase
    return f;
  endfunction

  // the four registers, reserved bits stored as written
  logic [7:0] deser_config_one_r;
  logic [7:0] bus_address_setup_r;
  logic [7:0] deser_features_one_r;
  logic [7:0] deser_features_two_r;
  logic [6:0] strap_address_r;
  logic strap_pending_r;

  // address decode
  wire logic hit0_w = (reg_addr_in == OFS_DESER_CONFIG_ONE);
  wire logic hit1_w = (reg_addr_in == OFS_BUS_ADDRESS_SETUP);
  wire logic hit2_w = (reg_addr_in == OFS_DESER_FEATURES_ONE);
  wire logic hit3_w = (reg_addr_in == OFS_DESER_FEATURES_TWO);
  wire logic mapped_w = hit0_w || hit1_w || hit2_w || hit3_w;
  wire logic powered_w = power_down_input_n_in;
  // writes are dropped while held in power-down, the bank is being restored
  wire logic wr_ok_w = reg_wr_en_in && powered_w;

  wire logic [7:0] rd_mux_w =
    hit0_w ? deser_config_one_r :
    hit1_w ? bus_address_setup_r :
    hit2_w ? deser_features_one_r :
    hit3_w ? deser_features_two_r : 8'h00;

  // one write strobe per register; wr_ok_w already drops writes in power-down
  wire logic wr0_w = wr_ok_w && hit0_w;
  wire logic wr1_w = wr_ok_w && hit1_w;
  wire logic wr2_w = wr_ok_w && hit2_w;
  wire logic wr3_w = wr_ok_w && hit3_w;

  // register storage: power-down reloads the reset values, stream stop does not touch it
  // full byte stored, reserved bits included
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      deser_config_one_r <= RST_DESER_CONFIG_ONE;
    else if (!powered_w)
      deser_config_one_r <= RST_DESER_CONFIG_ONE;
    else if (wr0_w)
      deser_config_one_r <= reg_wdata_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus_address_setup_r <= RST_BUS_ADDRESS_SETUP;
    else if (!powered_w)
      bus_address_setup_r <= RST_BUS_ADDRESS_SETUP;
    else if (wr1_w)
      bus_address_setup_r <= reg_wdata_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      deser_features_one_r <= RST_DESER_FEATURES_ONE;
    else if (!powered_w)
      deser_features_one_r <= RST_DESER_FEATURES_ONE;
    else if (wr2_w)
      deser_features_one_r <= reg_wdata_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      deser_features_two_r <= RST_DESER_FEATURES_TWO;
    else if (!powered_w)
      deser_features_two_r <= RST_DESER_FEATURES_TWO;
    else if (wr3_w)
      deser_features_two_r <= reg_wdata_in;
  end

  // address strap: caught on the first edge after reset or power-down release
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strap_pending_r <= 1'b1;
      strap_address_r <= BUS_ADDR_3;
    end
    else if (!powered_w)
      strap_pending_r <= 1'b1;
    else if (strap_pending_r)
    begin
      strap_pending_r <= 1'b0;
      strap_address_r <= strap_addr(addr_select_level_in);
    end
  end

  // read port answers one cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rdata_valid_out <= 1'b0;
      reg_addr_err_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= reg_rd_en_in ? rd_mux_w : 8'h00;
      reg_rdata_valid_out <= reg_rd_en_in;
      reg_addr_err_out <= (reg_rd_en_in || reg_wr_en_in) && !mapped_w;
    end
  end

  // source selection
  wire logic use_reg_w = deser_config_one_r[BIT_REG_CONTROL];
  wire logic lfr_nxt = use_reg_w ? deser_config_one_r[BIT_LOW_FREQ_RANGE] :
    pin_low_freq_range_sel_in;
  wire logic oss_nxt = use_reg_w ? deser_config_one_r[BIT_OUT_SLEEP_SEL] :
    pin_output_sleep_state_sel_in;
  // sleep bit is a register setting, so pin mode ignores it
  wire logic sleep_nxt = (use_reg_w && deser_config_one_r[BIT_SLEEP]) ||
    stream_stopped_in;
  // address source follows its own select bit, not the register control bit
  wire logic [6:0] addr_nxt = bus_address_setup_r[BIT_ADDR_FROM_REG] ?
    bus_address_setup_r[ADDR_FIELD_MSB:0] : strap_address_r;
  wire logic drive_nxt = use_reg_w ? deser_features_one_r[BIT_DRIVE_ON] :
    pin_video_output_drive_on_in;
  wire logic swing_nxt = use_reg_w ? deser_features_one_r[BIT_SWING_SEL] :
    pin_output_swing_sel_in;
  wire logic [2:0] osc_nxt = use_reg_w ? deser_features_one_r[OSC_MSB:0] :
    pin_internal_osc_freq_sel_in;
  wire logic boost_nxt = use_reg_w ? deser_features_two_r[BIT_BOOST_ON] :
    pin_input_boost_on_in;
  wire logic [2:0] gain_nxt = use_reg_w ? deser_features_two_r[GAIN_MSB:GAIN_LSB] :
    pin_input_boost_gain_in;
  wire logic [2:0] spread_sel_nxt = use_reg_w ? deser_features_two_r[SPREAD_MSB:0] :
    pin_spread_profile_sel_in;
  // gain in milli-dB, equal steps from one step at code 0
  wire logic [13:0] gain_mdb_nxt = 14'(GAIN_STEP_MDB * ({11'h000, gain_nxt} + 14'h0001));

  wire logic spread_on_nxt;
  wire logic [7:0] spread_dev_nxt;
  wire logic [11:0] spread_div_nxt;

  spread_profile_decode u_spread (
    .low_freq_range_sel_in(lfr_nxt),
    .spread_profile_sel_in(spread_sel_nxt),
    .spread_on_out(spread_on_nxt),
    .spread_dev_out(spread_dev_nxt),
    .spread_div_out(spread_div_nxt)
  );

  // effective settings, registered so the analog side sees no decode glitches
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_control_out <= 1'b0;
      sleep_out <= 1'b0;
      output_sleep_state_sel_out <= 1'b0;
      device_address_out <= BUS_ADDR_3;
      device_address_reserved_out <= 1'b0;
    end
    else
    begin
      reg_control_out <= use_reg_w;
      sleep_out <= sleep_nxt;
      output_sleep_state_sel_out <= oss_nxt;
      device_address_out <= addr_nxt;
      device_address_reserved_out <= !addr_valid(addr_nxt);
    end
  end

  // output stage and oscillator settings
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      video_output_drive_on_out <= 1'b0;
      output_swing_sel_out <= 1'b0;
      internal_osc_freq_sel_out <= OSC_CODE_OFF;
      osc_freq_khz_out <= 15'h0000;
      internal_osc_freq_sel_reserved_out <= 1'b0;
    end
    else
    begin
      video_output_drive_on_out <= drive_nxt;
      output_swing_sel_out <= swing_nxt;
      internal_osc_freq_sel_out <= osc_nxt;
      osc_freq_khz_out <= osc_khz(osc_nxt);
      internal_osc_freq_sel_reserved_out <= (osc_nxt == OSC_CODE_RSVD);
    end
  end

  // equalizer and spread settings
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      input_boost_on_out <= 1'b0;
      input_boost_gain_out <= 3'h0;
      boost_gain_mdb_out <= 14'h0000;
      low_freq_range_sel_out <= 1'b0;
      spread_on_out <= 1'b0;
      spread_dev_out <= 8'h00;
      spread_div_out <= 12'h000;
    end
    else
    begin
      input_boost_on_out <= boost_nxt;
      input_boost_gain_out <= gain_nxt;
      boost_gain_mdb_out <= gain_mdb_nxt;
      low_freq_range_sel_out <= lfr_nxt;
      spread_on_out <= spread_on_nxt;
      spread_dev_out <= spread_dev_nxt;
      spread_div_out <= spread_div_nxt;
    end
  end
endmodule

// *** sim/deser_cfg_assertions.sv ***
`timescale 1ns/1ps
module deser_cfg_assertions (
  // watched ports
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic power_down_input_n_in,
  input wire logic stream_stopped_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rdata_valid_out,
  input wire logic reg_addr_err_out,
  input wire logic pin_video_output_drive_on_in,
  input wire logic reg_control_out,
  input wire logic sleep_out,
  input wire logic [6:0] device_address_out,
  input wire logic device_address_reserved_out,
  input wire logic video_output_drive_on_out,
  input wire logic [2:0] internal_osc_freq_sel_out,
  input wire logic internal_osc_freq_sel_reserved_out,
  input wire logic spread_on_out,
  input wire logic [7:0] spread_dev_out,
  input wire logic [11:0] spread_div_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_STREAM_SLEEP: assert property (stream_stopped_in |=> sleep_out)
    else $error("stream stop did not sleep");
  AST_PIN_SLEEP: assert property (!reg_control_out && !$past(stream_stopped_in) |-> !sleep_out)
    else $error("sleep without register control");
  AST_PIN_DRIVE: assert property ($past(rst_n_in) && !reg_control_out
    |-> video_output_drive_on_out == $past(pin_video_output_drive_on_in))
    else $error("drive enable not from pin");
  AST_OSC_RSVD: assert property ($stable(internal_osc_freq_sel_out)
    |-> internal_osc_freq_sel_reserved_out == (internal_osc_freq_sel_out == 3'h1))
    else $error("oscillator reserved flag wrong");
  AST_ADDR_RSVD: assert property ($stable(device_address_out)
    |-> device_address_reserved_out == !(device_address_out inside {7'h71, 7'h72, 7'h73, 7'h76}))
    else $error("address reserved flag wrong");
  AST_RD_IDLE: assert property (!$past(reg_rd_en_in)
    |-> !reg_rdata_valid_out && reg_rdata_out == 8'h00)
    else $error("read data without read");
  AST_UNMAPPED: assert property (reg_rd_en_in && reg_addr_in > 8'h03
    |=> reg_addr_err_out && reg_rdata_valid_out && reg_rdata_out == 8'h00)
    else $error("unmapped read not flagged");
  AST_SPREAD_OFF: assert property (!spread_on_out
    |-> spread_dev_out == 8'h00 && spread_div_out == 12'h000)
    else $error("spread values while off");
  AST_POWER_DOWN: assert property (!power_down_input_n_in |-> ##2 !reg_control_out)
    else $error("power-down kept register control");
endmodule
bind deser_config_register_bank deser_cfg_assertions chk_i (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .power_down_input_n_in(power_down_input_n_in),
  .stream_stopped_in(stream_stopped_in),
  .reg_rd_en_in(reg_rd_en_in),
  .reg_addr_in(reg_addr_in),
  .reg_rdata_out(reg_rdata_out),
  .reg_rdata_valid_out(reg_rdata_valid_out),
  .reg_addr_err_out(reg_addr_err_out),
  .pin_video_output_drive_on_in(pin_video_output_drive_on_in),
  .reg_control_out(reg_control_out),
  .sleep_out(sleep_out),
  .device_address_out(device_address_out),
  .device_address_reserved_out(device_address_reserved_out),
  .video_output_drive_on_out(video_output_drive_on_out),
  .internal_osc_freq_sel_out(internal_osc_freq_sel_out),
  .internal_osc_freq_sel_reserved_out(internal_osc_freq_sel_reserved_out),
  .spread_on_out(spread_on_out),
  .spread_dev_out(spread_dev_out),
  .spread_div_out(spread_div_out)
);

// *** sim/host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model (
  // answer from the bank
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic valid_in,
  // requests
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    // released data must not look like a valid byte
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge clk_in);
    #1;
    rd_out = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    q = {valid_in, rdata_in};
  endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import deser_cfg_pkg::*;
  logic clk_in, rst_n_in, pd_n, stop, wr, rd, ctl, slp, oss, rsv, drv, sw, ors, bon, lf, son;
  logic [7:0] addr, wdata, rdata, dev;
  logic vld, err;
  logic [1:0] lvl;
  logic [13:0] pin;
  logic [6:0] da;
  logic [2:0] osc, gn;
  logic [14:0] khz;
  logic [13:0] mdb;
  logic [11:0] div;
  logic [8:0] q;
  logic [7:0] r0, r2, r3;
  logic [6:0] atab [4] = '{BUS_ADDR_0, BUS_ADDR_1, BUS_ADDR_2, BUS_ADDR_3};
  logic [7:0] rstv [4] = '{RST_DESER_CONFIG_ONE, RST_BUS_ADDRESS_SETUP,
    RST_DESER_FEATURES_ONE, RST_DESER_FEATURES_TWO};
  int okhz [8] = '{0, 0, 25000, 16700, 12500, 10000, 8300, 6300};
  int d0 [8] = '{0, 90, 120, 190, 230, 70, 130, 157};
  int d1 [8] = '{0, 70, 130, 180, 220, 70, 120, 170};
  int error_cnt, checks, seed, i;
  deser_config_register_bank DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .power_down_input_n_in(pd_n), .stream_stopped_in(stop), .reg_wr_en_in(wr),
    .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rdata_valid_out(vld), .reg_addr_err_out(err), .addr_select_level_in(lvl),
    .pin_low_freq_range_sel_in(pin[13]), .pin_output_sleep_state_sel_in(pin[12]),
    .pin_video_output_drive_on_in(pin[11]), .pin_output_swing_sel_in(pin[10]),
    .pin_internal_osc_freq_sel_in(pin[9:7]), .pin_input_boost_on_in(pin[6]),
    .pin_input_boost_gain_in(pin[5:3]), .pin_spread_profile_sel_in(pin[2:0]),
    .reg_control_out(ctl), .sleep_out(slp), .output_sleep_state_sel_out(oss),
    .device_address_out(da), .device_address_reserved_out(rsv),
    .video_output_drive_on_out(drv), .output_swing_sel_out(sw),
    .internal_osc_freq_sel_out(osc), .osc_freq_khz_out(khz), .internal_osc_freq_sel_reserved_out(ors),
    .input_boost_on_out(bon), .input_boost_gain_out(gn), .boost_gain_mdb_out(mdb),
    .low_freq_range_sel_out(lf), .spread_on_out(son), .spread_dev_out(dev),
    .spread_div_out(div));
  host_bus_model host (.clk_in(clk_in), .rdata_in(rdata), .valid_in(vld), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  function automatic logic [20:0] spr(logic l, logic [2:0] c);
    int dv;
    dv = l ? d1[c] : d0[c];
    if (c == 3'h0)
      return 21'h00_0000;
    return {1'b1, 8'(dv), (c < 3'h5) ? (l ? 12'd625 : 12'd2168) : (l ? 12'd385 : 12'd1300)};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    seed = 32'h2877;
    rst_n_in = 1'b0;
    pd_n = 1'b1;
    stop = 1'b0;
    lvl = 2'($random(seed));
    pin = 14'($random(seed));
    repeat (16) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    cyc(3);
    chk(da, atab[lvl]);
    for (i = 0; i < 4; i++)
    begin
      host.rd(8'(i), q);
      chk(q, {1'b1, rstv[i]});
    end
    repeat (12)
    begin
      r0 = 8'($random(seed)) & 8'h03;
      r2 = 8'($random(seed));
      host.wr(r0, r2);
      host.rd(r0, q);
      chk(q, {1'b1, r2});
    end
    host.wr(8'h00, 8'h3c);
    host.wr(8'h04, 8'hff);
    host.rd(8'h04 | 8'($random(seed)), q);
    chk({err, q}, 10'h300);
    host.rd(8'h00, q);
    chk(q, 9'h13c);
    for (i = 0; i < 16; i++)
    begin
      r0 = {i[0], 1'($random(seed)), 6'h01};
      r2 = 8'($random(seed));
      r3 = {5'($random(seed)), i[3:1]};
      pin = 14'($random(seed));
      host.wr(8'h00, r0);
      host.wr(8'h02, r2);
      host.wr(8'h03, r3);
      cyc(2);
      chk({ctl, drv, sw, osc, lf, oss, bon, gn},
        {1'b1, r2[7], r2[3], r2[2:0], r0[7:6], r3[4], r3[7:5]});
      chk({ors, khz}, {r2[2:0] == 3'h1, 15'(okhz[r2[2:0]])});
      chk(mdb, 14'd1625 * (14'(r3[7:5]) + 14'd1));
      chk({son, dev, div}, spr(r0[7], r3[2:0]));
      host.wr(8'h00, 8'h00);
      cyc(2);
      chk({ctl, lf, oss, drv, sw, osc, bon, gn}, {1'b0, pin[13:3]});
      chk({son, dev, div}, spr(pin[13], pin[2:0]));
    end
    host.wr(8'h00, 8'h03);
    cyc(2);
    chk(slp, 1'b1);
    host.wr(8'h00, 8'h41);
    cyc(2);
    chk({slp, oss}, 2'b01);
    stop = 1'b1;
    cyc(2);
    chk(slp, 1'b1);
    host.rd(8'h00, q);
    chk(q, 9'h141);
    stop = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      host.wr(8'h01, 8'hf5);
      lvl = 2'(i);
      pd_n = 1'b0;
      cyc(2);
      pd_n = 1'b1;
      cyc(3);
      chk(da, atab[i]);
      host.rd(8'h01, q);
      chk(q, {1'b1, RST_BUS_ADDRESS_SETUP});
    end
    host.wr(8'h01, 8'hf3);
    cyc(2);
    chk({rsv, da}, 8'h73);
    host.wr(8'h01, 8'hf0);
    cyc(3);
    chk({rsv, da}, 8'hf0);
    stop_test();
  end
endmodule
